// [design/tic_map.vh]
// register offsets, field positions and reset values of the input capture block
`ifndef TIC_MAP_VH
`define TIC_MAP_VH

// byte addresses, one aligned 32-bit word per register
`define TIC_OFF_CTRL1     8'h00
`define TIC_OFF_CTRL2     8'h04
`define TIC_OFF_STATUS    8'h08
`define TIC_OFF_CAP1_HI   8'h0c
`define TIC_OFF_CAP1_LO   8'h10
`define TIC_OFF_CAP2_HI   8'h14
`define TIC_OFF_CAP2_LO   8'h18
`define TIC_OFF_IRQ_STAT  8'h1c
`define TIC_OFF_IRQ_MASK  8'h20

// timer_control_one fields
`define TIC_C1_IRQ_EN     7
`define TIC_C1_OVF_EN     5
`define TIC_C1_EDGE1      1
// timer_control_two fields
`define TIC_C2_EDGE2      1
`define TIC_C2_PRE_LO     2
`define TIC_C2_PRE_HI     3
// timer_status_reg fields
`define TIC_SR_FLAG1      0
`define TIC_SR_FLAG2      1
`define TIC_SR_OVF        2
// interrupt status / mask fields
`define TIC_IRQ_CAP1      0
`define TIC_IRQ_CAP2      1
`define TIC_IRQ_OVF       2
`define TIC_IRQ_W         3

// reset values
`define TIC_RST_IRQ_MASK  3'h0
`define TIC_RST_CAP       16'h0000
`define TIC_RST_PRE       2'h0

// axi responses
`define TIC_RESP_OKAY     2'h0
`define TIC_RESP_SLVERR   2'h2

// cycles after reset before edge detection trusts the synchroniser
`define TIC_PRIME_CYCLES  2'h3

`endif

// [design/tic_edge_sync.v]
// pin synchroniser with selectable edge detector for one capture channel
`include "tic_map.vh"

module tic_edge_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire capture_input_pin,
  input  wire capture_edge_select,
  output wire edge_pulse
);

  reg       sync_a;
  reg       sync_b;
  reg       prev;
  reg [1:0] prime;

  // two flops before any logic; prime blocks a false edge right after reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
      prime  <= 2'h0;
    end else begin
      sync_a <= capture_input_pin;
      sync_b <= sync_a;
      prev   <= sync_b;
      if (prime != `TIC_PRIME_CYCLES)
        prime <= prime + 2'h1;
    end
  end

  // edge select 1 picks rising, 0 picks falling
  assign edge_pulse = (prime == `TIC_PRIME_CYCLES) &
                      (capture_edge_select ? (sync_b & ~prev) : (~sync_b & prev));

endmodule // tic_edge_sync

// [design/tic_top.v]
// input capture part of a 16-bit timer with an axi4-lite register slave
`include "tic_map.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - two 16-bit capture registers copy the counter on an active pin edge
// - each capture reads as high and low byte; writes never change it
// - per channel an edge-select bit picks rising or falling edge
// - resolution is one counter count; two-bit prescale select drives the counter
// - channel 2 edge bit in control two; channel 1 and enable in control one
// - one capture interrupt enable covers both channels
// - active edge sets the channel flag and loads the counter value
// - interrupt raised when irq_status bit, enable and irq_mask bit set and cpu mask clear; else pending
// - flag clears after status read while set, then low byte access
// - high byte read blocks capture and flag until the low byte is read
// - capture register always holds the latest accepted capture value
// - both channels keep working while output compares are in use
// - in one-pulse or pwm mode only channel 2 captures
// - pins always feed the capture logic; high byte read masks them
// - counter overflow flag can raise an interrupt for longer measurements
// - one timer interrupt line per instance, no wake from halt
module tic_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        capture_input_pin1,
  input  wire        capture_input_pin2,
  input  wire [15:0] counter_value,
  input  wire        counter_overflow_flag,
  input  wire        one_pulse_mode,
  input  wire        pwm_mode,
  input  wire        cpu_irq_mask,
  output reg  [1:0]  timer_prescale_select,
  output reg         timer_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  reg                  capture_irq_enable;
  reg                  overflow_irq_enable;
  reg                  edge_sel1;
  reg                  edge_sel2;
  reg  [1:0]           capture_flag;
  reg  [1:0]           clear_armed;
  reg  [1:0]           read_lock;
  reg  [15:0]          capture_value [0:1];
  reg  [`TIC_IRQ_W-1:0] irq_status;
  reg  [`TIC_IRQ_W-1:0] irq_mask;
  reg                  overflow_prev;

  reg                  aw_held;
  reg                  w_held;
  reg  [7:0]           wr_addr;
  reg  [31:0]          wr_data;
  reg                  wr_lane0;

  reg  [31:0]          rd_word;
  reg                  rd_ok;
  reg                  wr_ok;

  wire [1:0]           edge_pulse;
  wire [1:0]           chan_enable;
  wire [1:0]           capture_hit;
  wire [1:0]           low_access;
  wire [1:0]           low_read;
  wire [1:0]           high_read;
  wire                 wr_fire;
  wire                 rd_fire;
  wire                 status_read;
  wire                 overflow_event;
  wire [`TIC_IRQ_W-1:0] irq_events;
  wire [`TIC_IRQ_W-1:0] irq_gate;
  wire [`TIC_IRQ_W-1:0] next_irq_status;
  wire                 next_timer_irq;

  integer              i;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detectors

  tic_edge_sync u_edge1 (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .capture_input_pin   (capture_input_pin1),
    .capture_edge_select (edge_sel1),
    .edge_pulse          (edge_pulse[0])
  );

  tic_edge_sync u_edge2 (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .capture_input_pin   (capture_input_pin2),
    .capture_edge_select (edge_sel2),
    .edge_pulse          (edge_pulse[1])
  );

  //////////////////////////////////////////////////////////////////////////////
  // access decode

  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  assign status_read = rd_fire & (s_axi_araddr == `TIC_OFF_STATUS);

  assign high_read[0] = rd_fire & (s_axi_araddr == `TIC_OFF_CAP1_HI);
  assign high_read[1] = rd_fire & (s_axi_araddr == `TIC_OFF_CAP2_HI);
  assign low_read[0]  = rd_fire & (s_axi_araddr == `TIC_OFF_CAP1_LO);
  assign low_read[1]  = rd_fire & (s_axi_araddr == `TIC_OFF_CAP2_LO);

  // a write to the low byte stores nothing but still counts as the access
  assign low_access[0] = low_read[0] | (wr_fire & (wr_addr == `TIC_OFF_CAP1_LO));
  assign low_access[1] = low_read[1] | (wr_fire & (wr_addr == `TIC_OFF_CAP2_LO));

  //////////////////////////////////////////////////////////////////////////////
  // capture qualification

  // channel 1 borrows its compare resources in one-pulse and pwm modes
  assign chan_enable[0] = ~(one_pulse_mode | pwm_mode);
  // output compare use never gates capture, so channel 2 is always live
  assign chan_enable[1] = 1'b1;

  // pins feed capture even when driven as outputs; the lock masks them, and one-pulse or pwm mode masks channel 1
  assign capture_hit = edge_pulse & chan_enable & ~read_lock;

  //////////////////////////////////////////////////////////////////////////////
  // capture registers, flags and the two-step clear

  always @(posedge aclk) begin
    if (!aresetn) begin
      capture_flag <= 2'h0;
      clear_armed  <= 2'h0;
      read_lock    <= 2'h0;
      for (i = 0; i < 2; i = i + 1)
        capture_value[i] <= `TIC_RST_CAP;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        // latest accepted edge always overwrites the previous value
        if (capture_hit[i])
          capture_value[i] <= counter_value;

        // a new capture wins over a clear in the same cycle
        if (capture_hit[i])
          capture_flag[i] <= 1'b1;
        else if (clear_armed[i] & low_access[i])
          capture_flag[i] <= 1'b0;

        if (low_access[i])
          clear_armed[i] <= 1'b0;
        else if (status_read & capture_flag[i])
          clear_armed[i] <= 1'b1;

        if (low_read[i])
          read_lock[i] <= 1'b0;
        else if (high_read[i])
          read_lock[i] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and request

  assign overflow_event = counter_overflow_flag & ~overflow_prev;

  assign irq_events = {overflow_event, capture_hit[1], capture_hit[0]};

  // write one to clear; an event in the same cycle keeps the bit set
  assign next_irq_status =
    (irq_status & ~((wr_fire & wr_lane0 & (wr_addr == `TIC_OFF_IRQ_STAT)) ?
                    wr_data[`TIC_IRQ_W-1:0] : {`TIC_IRQ_W{1'b0}})) | irq_events;

  // one shared enable for both captures, its own enable for overflow
  assign irq_gate = {overflow_irq_enable, capture_irq_enable, capture_irq_enable};

  // request waits while the cpu mask is set and rises once it clears
  assign next_timer_irq = ~cpu_irq_mask & (|(irq_status & irq_mask & irq_gate));

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status    <= {`TIC_IRQ_W{1'b0}};
      overflow_prev <= 1'b0;
      timer_irq     <= 1'b0;
    end else begin
      irq_status    <= next_irq_status;
      overflow_prev <= counter_overflow_flag;
      timer_irq     <= next_timer_irq;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control register writes

  always @(posedge aclk) begin
    if (!aresetn) begin
      capture_irq_enable    <= 1'b0;
      overflow_irq_enable   <= 1'b0;
      edge_sel1             <= 1'b0;
      edge_sel2             <= 1'b0;
      timer_prescale_select <= `TIC_RST_PRE;
      irq_mask              <= `TIC_RST_IRQ_MASK;
    end else if (wr_fire & wr_lane0) begin
      if (wr_addr == `TIC_OFF_CTRL1) begin
        capture_irq_enable  <= wr_data[`TIC_C1_IRQ_EN];
        overflow_irq_enable <= wr_data[`TIC_C1_OVF_EN];
        edge_sel1           <= wr_data[`TIC_C1_EDGE1];
      end else if (wr_addr == `TIC_OFF_CTRL2) begin
        edge_sel2             <= wr_data[`TIC_C2_EDGE2];
        timer_prescale_select <= wr_data[`TIC_C2_PRE_HI:`TIC_C2_PRE_LO];
      end else if (wr_addr == `TIC_OFF_IRQ_MASK) begin
        irq_mask <= wr_data[`TIC_IRQ_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address check for writes

  // capture bytes accept the write without storing it, so they answer okay
  always @* begin
    wr_ok = 1'b1;
    if (wr_addr == `TIC_OFF_CTRL1)
      wr_ok = 1'b1;
    else if (wr_addr == `TIC_OFF_CTRL2)
      wr_ok = 1'b1;
    else if (wr_addr == `TIC_OFF_STATUS)
      wr_ok = 1'b1;
    else if (wr_addr == `TIC_OFF_CAP1_HI || wr_addr == `TIC_OFF_CAP1_LO)
      wr_ok = 1'b1;
    else if (wr_addr == `TIC_OFF_CAP2_HI || wr_addr == `TIC_OFF_CAP2_LO)
      wr_ok = 1'b1;
    else if (wr_addr == `TIC_OFF_IRQ_STAT || wr_addr == `TIC_OFF_IRQ_MASK)
      wr_ok = 1'b1;
    else
      wr_ok = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data selection

  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (s_axi_araddr == `TIC_OFF_CTRL1) begin
      rd_word[`TIC_C1_IRQ_EN] = capture_irq_enable;
      rd_word[`TIC_C1_OVF_EN] = overflow_irq_enable;
      rd_word[`TIC_C1_EDGE1]  = edge_sel1;
    end else if (s_axi_araddr == `TIC_OFF_CTRL2) begin
      rd_word[`TIC_C2_EDGE2]                = edge_sel2;
      rd_word[`TIC_C2_PRE_HI:`TIC_C2_PRE_LO] = timer_prescale_select;
    end else if (s_axi_araddr == `TIC_OFF_STATUS) begin
      rd_word[`TIC_SR_FLAG1] = capture_flag[0];
      rd_word[`TIC_SR_FLAG2] = capture_flag[1];
      rd_word[`TIC_SR_OVF]   = counter_overflow_flag;
    end else if (s_axi_araddr == `TIC_OFF_CAP1_HI) begin
      rd_word[7:0] = capture_value[0][15:8];
    end else if (s_axi_araddr == `TIC_OFF_CAP1_LO) begin
      rd_word[7:0] = capture_value[0][7:0];
    end else if (s_axi_araddr == `TIC_OFF_CAP2_HI) begin
      rd_word[7:0] = capture_value[1][15:8];
    end else if (s_axi_araddr == `TIC_OFF_CAP2_LO) begin
      rd_word[7:0] = capture_value[1][7:0];
    end else if (s_axi_araddr == `TIC_OFF_IRQ_STAT) begin
      rd_word[`TIC_IRQ_W-1:0] = irq_status;
    end else if (s_axi_araddr == `TIC_OFF_IRQ_MASK) begin
      rd_word[`TIC_IRQ_W-1:0] = irq_mask;
    end else begin
      rd_ok = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channels

  // address and data are taken in either order and held until both are in
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TIC_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h0000_0000;
      wr_lane0      <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held       <= 1'b1;
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held       <= 1'b1;
        wr_data      <= s_axi_wdata;
        wr_lane0     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `TIC_RESP_OKAY : `TIC_RESP_SLVERR;
      end
      // reopen both channels only once the response is taken
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channels

  // reads have side effects, so a read is taken once and answered once
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TIC_RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? `TIC_RESP_OKAY : `TIC_RESP_SLVERR;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // tic_top

// [sim/tic_pin_src.sv]
// external signal sources driving the two capture pins
module tic_pin_src (
  input  wire want1,
  input  wire want2,
  output wire capture_input_pin1,
  output wire capture_input_pin2
);
  timeunit 1ns;
  timeprecision 1ns;
  // push-pull sources, plain inputs at the block, no pin interrupt path
  // pins move 17 ns after the request, off the clock edge, as a real source would
  assign #17 capture_input_pin1 = want1;
  assign #17 capture_input_pin2 = want2;
endmodule // tic_pin_src

// [sim/tic_monitor.sv]
// assertion checker for the capture block ports
module tic_monitor (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        cpu_irq_mask,
  input wire [1:0]  timer_prescale_select,
  input wire        timer_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence w_answer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  chk_irq_cpu_mask: assert property (cpu_irq_mask |=> !timer_irq)
    else $error("timer irq high while cpu mask set");
  // a write may clear status or mask, so only a quiet bus keeps the request pending
  chk_irq_stays_pending: assert property (
    timer_irq && !cpu_irq_mask && !s_axi_bvalid |=> timer_irq)
    else $error("pending timer irq dropped");
  chk_prescale_write: assert property (
    $changed(timer_prescale_select) |-> $rose(s_axi_bvalid))
    else $error("prescale select changed without a write");
  chk_read_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("register read wider than a byte");
  chk_read_data_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_write_resp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_read_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_write_answer: assert property (w_take |=> w_answer)
    else $error("write answer late");
endmodule // tic_monitor

bind tic_top tic_monitor tic_monitor_inst (.*);

// [sim/timer_input_capture_tb.sv]
// self-checking bench for the input capture block
`include "tic_map.vh"
module timer_input_capture_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, want1, want2, counter_overflow_flag;
  reg         one_pulse_mode, pwm_mode, cpu_irq_mask;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  reg  [15:0] counter_value;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        timer_irq, capture_input_pin1, capture_input_pin2;
  wire [1:0]  s_axi_bresp, s_axi_rresp, timer_prescale_select;
  wire [31:0] s_axi_rdata;
  integer     fails, n_compared;
  tic_top tic_top_inst (.*);
  tic_pin_src tic_pin_src_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  ////////////////////////////////////////
  task stop_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er = `TIC_RESP_OKAY,
              input slow = 1'b0);
    integer n;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !slow;
      n = 0;
      do begin
        @(posedge aclk);
        n = n + 1;
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        // a late bready lets the response stand for a few cycles
        if (n == 4 && slow) s_axi_bready <= 1'b1;
      end while ((s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1) && n < 100);
      s_axi_bready <= 1'b0;
      if (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1) begin
        fails = fails + 1;
        stop_test;
      end else begin
        chk({30'h0, s_axi_bresp}, {30'h0, er});
      end
    end
  endtask
  task axi_rd(input [7:0] a, input [31:0] exp, input [1:0] er = `TIC_RESP_OKAY,
              input slow = 1'b0);
    integer n;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !slow;
      n = 0;
      do begin
        @(posedge aclk);
        n = n + 1;
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        // a late rready lets the read data stand for a few cycles
        if (n == 3 && slow) s_axi_rready <= 1'b1;
      end while ((s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1) && n < 100);
      s_axi_rready <= 1'b0;
      if (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1) begin
        fails = fails + 1;
        stop_test;
      end else begin
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
    end
  endtask
  // counter held still around the edge so the expected capture does not hang on latency
  task pin(input ch, input lvl, input [15:0] cnt);
    begin
      @(posedge aclk);
      counter_value <= cnt;
      if (ch) want2 <= lvl;
      else want1 <= lvl;
      repeat (8) @(posedge aclk);
      counter_value <= ~cnt;
    end
  endtask
  task irq(input exp);
    begin
      repeat (3) @(posedge aclk);
      chk({31'h0, timer_irq}, {31'h0, exp});
    end
  endtask
  ////////////////////////////////////////
  task s_reset;
    integer i;
    begin
      for (i = 0; i < 9; i = i + 1) axi_rd(8'(i * 4), 32'h0);
      axi_rd(8'h24, 32'h0, `TIC_RESP_SLVERR);
      axi_wr(8'h28, 32'h1, `TIC_RESP_SLVERR);
      chk({30'h0, timer_prescale_select}, 32'h0);
    end
  endtask
  task s_capture;
    begin
      axi_wr(`TIC_OFF_CTRL1, 32'h2);
      axi_wr(`TIC_OFF_CTRL2, 32'h0);
      pin(0, 1'b1, 16'h1234);
      pin(1, 1'b1, 16'h0bad);
      axi_rd(`TIC_OFF_STATUS, 32'h1, `TIC_RESP_OKAY, 1'b1);
      axi_rd(`TIC_OFF_CAP1_HI, 32'h12);
      axi_wr(`TIC_OFF_CAP1_LO, 32'hff, `TIC_RESP_OKAY, 1'b1);
      axi_rd(`TIC_OFF_CAP1_LO, 32'h34);
      axi_rd(`TIC_OFF_STATUS, 32'h0);
      pin(1, 1'b0, 16'h0bad);
      axi_rd(`TIC_OFF_STATUS, 32'h2);
      axi_rd(`TIC_OFF_CAP2_HI, 32'h0b);
      axi_rd(`TIC_OFF_CAP2_LO, 32'had);
      axi_rd(`TIC_OFF_STATUS, 32'h0);
    end
  endtask
  task s_overwrite;
    begin
      pin(0, 1'b0, 16'h0001);
      axi_rd(`TIC_OFF_STATUS, 32'h0);
      pin(0, 1'b1, 16'h4321);
      pin(0, 1'b0, 16'h0002);
      pin(0, 1'b1, 16'h5678);
      axi_rd(`TIC_OFF_CAP1_LO, 32'h78);
      axi_rd(`TIC_OFF_STATUS, 32'h1);
      axi_rd(`TIC_OFF_CAP1_HI, 32'h56);
      axi_rd(`TIC_OFF_CAP1_LO, 32'h78);
      axi_rd(`TIC_OFF_STATUS, 32'h0);
    end
  endtask
  task s_lock;
    begin
      axi_rd(`TIC_OFF_CAP2_HI, 32'h0b);
      pin(1, 1'b1, 16'h0000);
      pin(1, 1'b0, 16'h7777);
      axi_rd(`TIC_OFF_STATUS, 32'h0);
      axi_rd(`TIC_OFF_CAP2_LO, 32'had);
      pin(1, 1'b1, 16'h0000);
      pin(1, 1'b0, 16'h8888);
      axi_rd(`TIC_OFF_STATUS, 32'h2);
      axi_rd(`TIC_OFF_CAP2_HI, 32'h88);
      axi_rd(`TIC_OFF_CAP2_LO, 32'h88);
    end
  endtask
  task s_modes;
    integer m;
    begin
      for (m = 0; m < 2; m = m + 1) begin
        one_pulse_mode <= (m == 0);
        pwm_mode <= (m == 1);
        pin(0, 1'b0, 16'h0000);
        pin(0, 1'b1, 16'h1111);
        pin(1, 1'b1, 16'h0000);
        pin(1, 1'b0, m ? 16'h3333 : 16'h2222);
        axi_rd(`TIC_OFF_STATUS, 32'h2);
        axi_rd(`TIC_OFF_CAP2_HI, m ? 32'h33 : 32'h22);
        axi_rd(`TIC_OFF_CAP2_LO, m ? 32'h33 : 32'h22);
      end
      one_pulse_mode <= 1'b0;
      pwm_mode <= 1'b0;
      // channel 1 must still hold its last value from before the modes
      axi_rd(`TIC_OFF_CAP1_HI, 32'h56);
      axi_rd(`TIC_OFF_CAP1_LO, 32'h78);
    end
  endtask
  task s_irq;
    begin
      axi_wr(`TIC_OFF_IRQ_STAT, 32'h7);
      axi_wr(`TIC_OFF_IRQ_MASK, 32'h7);
      axi_wr(`TIC_OFF_CTRL1, 32'h82);
      cpu_irq_mask <= 1'b1;
      pin(0, 1'b0, 16'h0000);
      pin(0, 1'b1, 16'h0042);
      irq(1'b0);
      cpu_irq_mask <= 1'b0;
      irq(1'b1);
      axi_rd(`TIC_OFF_IRQ_STAT, 32'h1);
      axi_wr(`TIC_OFF_IRQ_STAT, 32'h1);
      irq(1'b0);
      pin(1, 1'b1, 16'h0000);
      pin(1, 1'b0, 16'h0099);
      irq(1'b1);
      axi_wr(`TIC_OFF_IRQ_MASK, 32'h0);
      irq(1'b0);
      axi_wr(`TIC_OFF_IRQ_MASK, 32'h7);
      irq(1'b1);
      axi_wr(`TIC_OFF_IRQ_STAT, 32'h2);
      counter_overflow_flag <= 1'b1;
      irq(1'b0);
      axi_wr(`TIC_OFF_STATUS, 32'h0);
      axi_rd(`TIC_OFF_STATUS, 32'h7);
      axi_wr(`TIC_OFF_CTRL1, 32'ha2);
      irq(1'b1);
      counter_overflow_flag <= 1'b0;
      axi_wr(`TIC_OFF_CTRL2, 32'hc);
      chk({30'h0, timer_prescale_select}, 32'h3);
      // with lane 0 off the write is answered but must store nothing
      s_axi_wstrb <= 4'h0;
      axi_wr(`TIC_OFF_CTRL2, 32'h0);
      s_axi_wstrb <= 4'h1;
      axi_rd(`TIC_OFF_CTRL2, 32'hc);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
    {s_axi_rready, want1, want2, counter_overflow_flag} = 4'h0;
    {one_pulse_mode, pwm_mode, cpu_irq_mask} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'h1;
    counter_value = 16'h0000;
    fails = 0;
    n_compared = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    s_reset;
    s_capture;
    s_overwrite;
    s_lock;
    s_modes;
    s_irq;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    s_reset;
    stop_test;
  end
endmodule // timer_input_capture_tb
